// ### adc_pkg.sv
`default_nettype none
package adc_pkg;
	localparam int RESULT_BITS = 20;
	localparam int CLK_MHZ = 50;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int CONV_MAX_NS = 1500;
	localparam int CONV_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int ACQ_START_NS = 675;
	localparam int ACQ_START_CYCLES = (ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNV_GLITCH_NS = 40;
	localparam int CNV_GLITCH_CYCLES = CNV_GLITCH_NS / CLK_PERIOD_NS;
	localparam int POR_WAIT_US = 200;
	localparam int POR_WAIT_CYCLES = (POR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_DIV = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int SDO_SETTLE_CYCLES = 4;
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 20'h00000;
endpackage
`default_nettype wire

// ### adc_link_if.sv
`default_nettype none
interface adc_link_if;
	logic convertStart;
	logic busy;
	logic sck;
	logic selOrSerialIn;
	logic sdoOut;
	logic sdoOen_n;
	logic sdo;
	assign sdo = sdoOen_n ? 1'b1 : sdoOut;
	modport device (input convertStart, input sck, input selOrSerialIn, output busy, output sdoOut, output sdoOen_n);
	modport host (output convertStart, output sck, output selOrSerialIn, input busy, input sdo);
endinterface
`default_nettype wire

// ### adc_fifo.sv
`default_nettype none
module adc_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q, rdPtr_q;
	logic doWr, doRd;
	assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem[rdPtr_q[AW-1:0]];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	// Storage
	always_ff @(posedge mclk) begin
		if (doWr) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end
	// Pointers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
			if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### adc_device.sv
`default_nettype none
// Notes on behaviour
// R1: Rising convert_start starts conversion, wakes device
// R2: Restart attempts ignored during conversion
// R3: Busy high throughout conversion, low after
// R4: Host avoids convert_start edges mid-conversion
// R5: Acquisition for next sample begins 675ns
// R6: Internal clock finishes conversion within 1.5us
// R7: Power-on reset reinitialises the converter
// R8: Host waits 200us after reset
// R9: Auto power-down after conversion completes
// R10: Result kept readable while powered down
// R11: Host stops SCK, disables output idle
// R12: SDO shifts only on host SCK edges
// R13: SDO updates on SCK rise, host samples later
// R14: result_msb shown before first SCK rise
// R15: Host runs SCK fast enough
// R16: Normal mode select high tristates SDO
// R17: Selected device shows new MSB at busy fall
// R18: Taking select low drives MSB immediately
// R19: Shared SDO hosts select one device
// R20: Chain mode always drives, select is serial
// R21: Chain captures upstream on every SCK rise
// R22: 20-bit MSB-first words, upstream follows
// R23: Shift register loads when busy falls
module adc_device
	import adc_pkg::*;
#(
	parameter int CONV_CYC = adc_pkg::CONV_CYCLES,
	parameter int ACQ_CYC = adc_pkg::ACQ_START_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	adc_link_if.device link,
	input wire logic daisyLinkSelect,
	input wire logic [adc_pkg::RESULT_BITS-1:0] sampleValue,
	output logic poweredUp,
	output logic acquiring
);
	import adc_pkg::*;
	typedef enum logic [0:0] {PWR_DOWN, CONVERTING} conv_state_t;
	conv_state_t state_q;
	logic [2:0] cnvSync_q, sckSync_q, selSync_q;
	logic [1:0] chainSync_q;
	logic [10:0] convCnt_q;
	logic [RESULT_BITS-1:0] shift_q;
	logic cnvRise, sckRise, selFall, convDone;
	// Pin synchronisers, third stage used only for edge history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnvSync_q <= '0;
			sckSync_q <= '0;
			selSync_q <= 3'h7;
			chainSync_q <= '0;
		end else begin
			cnvSync_q <= {cnvSync_q[1:0], link.convertStart};
			sckSync_q <= {sckSync_q[1:0], link.sck};
			selSync_q <= {selSync_q[1:0], link.selOrSerialIn};
			chainSync_q <= {chainSync_q[0], daisyLinkSelect};
		end
	end
	assign cnvRise = cnvSync_q[1] && !cnvSync_q[2];
	assign sckRise = sckSync_q[1] && !sckSync_q[2];
	assign selFall = !selSync_q[1] && selSync_q[2];
	assign convDone = (state_q == CONVERTING) && (convCnt_q == 11'(CONV_CYC - 1));
	// Conversion timing from the internal clock; reset is the power-on reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin // R7
			state_q <= PWR_DOWN;
			convCnt_q <= '0;
		end else begin
			unique case (state_q)
				PWR_DOWN: begin
					convCnt_q <= '0;
					if (cnvRise) state_q <= CONVERTING; // R1
				end
				CONVERTING: begin
					convCnt_q <= convCnt_q + 1'b1; // R2
					if (convDone) state_q <= PWR_DOWN; // R6 R9
				end
			endcase
		end
	end
	// Status outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link.busy <= 1'b0;
			poweredUp <= 1'b0;
			acquiring <= 1'b1;
		end else begin
			link.busy <= (state_q == PWR_DOWN) ? cnvRise : !convDone; // R3
			poweredUp <= (state_q == PWR_DOWN) ? cnvRise : !convDone;
			if (cnvRise && state_q == PWR_DOWN) acquiring <= 1'b0;
			else if (state_q == CONVERTING && convCnt_q == 11'(ACQ_CYC - 1)) acquiring <= 1'b1; // R5
		end
	end
	// Output shift register; loaded at conversion end, shifted on each SCK rise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_q <= RESULT_RESET;
		end else if (convDone) begin
			shift_q <= sampleValue; // R23 R17 R10
		end else if (sckRise) begin
			shift_q <= {shift_q[RESULT_BITS-2:0], chainSync_q[1] ? selSync_q[1] : 1'b0}; // R12 R21 R22
		end
	end
	// SDO drive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link.sdoOut <= 1'b0;
			link.sdoOen_n <= 1'b1;
		end else begin
			if (convDone) link.sdoOut <= sampleValue[RESULT_BITS-1]; // R17
			else if (sckRise) link.sdoOut <= shift_q[RESULT_BITS-2]; // R13
			else if (selFall) link.sdoOut <= shift_q[RESULT_BITS-1]; // R18 R14
			else link.sdoOut <= shift_q[RESULT_BITS-1]; // R14
			link.sdoOen_n <= chainSync_q[1] ? 1'b0 : selSync_q[1]; // R16 R20
		end
	end
endmodule
`default_nettype wire

// ### adc_host.sv
`default_nettype none
module adc_host
	import adc_pkg::*;
#(
	parameter int POR_CYC = adc_pkg::POR_WAIT_CYCLES,
	parameter int WORD_BITS = adc_pkg::RESULT_BITS
) (
	input wire logic mclk,
	input wire logic rst_n,
	adc_link_if.host link,
	input wire logic startReq,
	output logic ready,
	output logic resultValid,
	input wire logic resultReady,
	output logic [adc_pkg::RESULT_BITS-1:0] resultData
);
	import adc_pkg::*;
	typedef enum logic [2:0] {POR_WAIT, IDLE, CNV_HI, WAIT_BUSY, SETTLE, SHIFT} host_state_t;
	host_state_t state_q;
	logic [17:0] porCnt_q;
	logic [4:0] bitCnt_q;
	logic [1:0] busySync_q, sdoSync_q;
	logic [RESULT_BITS-1:0] word_q;
	logic divCnt_q, fifoReady, pushValid_q, fifoValid;
	logic [RESULT_BITS-1:0] fifoData;
	// Synchronise device pins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busySync_q <= '0;
			sdoSync_q <= '0;
		end else begin
			busySync_q <= {busySync_q[0], link.busy};
			sdoSync_q <= {sdoSync_q[0], link.sdo};
		end
	end
	// Sequencer: convert, wait busy low, then shift word out
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= POR_WAIT;
			porCnt_q <= '0;
			bitCnt_q <= '0;
			divCnt_q <= 1'b0;
			link.convertStart <= 1'b0;
			link.sck <= 1'b0;
			link.selOrSerialIn <= 1'b1;
			word_q <= '0;
			pushValid_q <= 1'b0;
			ready <= 1'b0;
		end else begin
			if (pushValid_q && fifoReady) pushValid_q <= 1'b0;
			unique case (state_q)
				POR_WAIT: begin
					porCnt_q <= porCnt_q + 1'b1;
					if (porCnt_q == 18'(POR_CYC - 1)) begin // R8
						state_q <= IDLE;
						ready <= 1'b1;
					end
				end
				IDLE: begin
					if (startReq && ready && !pushValid_q) begin
						link.convertStart <= 1'b1;
						ready <= 1'b0;
						state_q <= CNV_HI;
					end else begin
						ready <= !pushValid_q || fifoReady; // No new start while the buffer is full
					end
				end
				CNV_HI: begin
					if (busySync_q[1]) state_q <= WAIT_BUSY;
				end
				WAIT_BUSY: begin
					if (!busySync_q[1]) begin // R4
						link.convertStart <= 1'b0;
						link.selOrSerialIn <= 1'b0;
						bitCnt_q <= '0;
						divCnt_q <= 1'b0;
						state_q <= SETTLE;
					end
				end
				// Let the first bit cross both synchronisers before any clock
				SETTLE: begin
					bitCnt_q <= bitCnt_q + 1'b1;
					if (bitCnt_q == 5'(SDO_SETTLE_CYCLES - 1)) begin // R18
						bitCnt_q <= '0;
						divCnt_q <= 1'b0;
						state_q <= SHIFT;
					end
				end
				// Sample on the falling edge we drive; round trip exceeds half a period
				SHIFT: begin
					divCnt_q <= !divCnt_q; // R15
					if (divCnt_q) begin
						link.sck <= !link.sck;
						if (link.sck) begin
							word_q <= {word_q[RESULT_BITS-2:0], sdoSync_q[1]}; // R13
							bitCnt_q <= bitCnt_q + 1'b1;
							if (bitCnt_q == 5'(WORD_BITS - 1)) begin
								link.selOrSerialIn <= 1'b1; // R11 R19
								pushValid_q <= 1'b1;
								state_q <= IDLE;
							end
						end
					end
				end
			endcase
		end
	end
	adc_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) adc_fifo_inst (
		.mclk(mclk), .rst_n(rst_n), .inValid(pushValid_q), .inReady(fifoReady), .inData(word_q),
		.outValid(fifoValid), .outReady(resultReady), .outData(fifoData)
	);
	// Registered FIFO head
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resultValid <= 1'b0;
			resultData <= '0;
		end else begin
			resultValid <= fifoValid;
			resultData <= fifoData;
		end
	end
endmodule
`default_nettype wire

// ### adc_link_checker.sv
`default_nettype none
module adc_link_checker #(
	parameter int CONV_CYC = 75
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic daisyLinkSelect,
	input wire logic convertStart,
	input wire logic busy,
	input wire logic sck,
	input wire logic selOrSerialIn,
	input wire logic sdoOut,
	input wire logic sdoOen_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] busyCnt_q;
	logic [3:0] still_q;
	logic sckPrev_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Busy length and cycles since the last SCK edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busyCnt_q <= 8'h00;
			still_q <= 4'h0;
			sckPrev_q <= 1'b0;
		end else begin
			busyCnt_q <= busy ? busyCnt_q + 8'h01 : 8'h00;
			still_q <= (sck != sckPrev_q) ? 4'h0 : still_q + {3'h0, still_q != 4'hf};
			sckPrev_q <= sck;
		end
	end
	property p_convMax; busy |-> busyCnt_q < 8'(CONV_CYC); endproperty
	a_convMax: assert property (p_convMax) else $error("busy held past conversion time");
	property p_start; $rose(convertStart) && !busy |-> ##[1:4] busy; endproperty
	a_start: assert property (p_start) else $error("start edge did not raise busy");
	property p_wake; $rose(busy) |-> $past(convertStart, 2) || $past(convertStart, 3) || $past(convertStart, 4); endproperty
	a_wake: assert property (p_wake) else $error("busy rose without a start edge");
	property p_tri; (!daisyLinkSelect && selOrSerialIn)[*4] |-> sdoOen_n; endproperty
	a_tri: assert property (p_tri) else $error("sdo driven while deselected");
	property p_drv; (!daisyLinkSelect && !selOrSerialIn)[*4] |-> !sdoOen_n; endproperty
	a_drv: assert property (p_drv) else $error("sdo not driven while selected");
	property p_chain; daisyLinkSelect[*4] |-> !sdoOen_n; endproperty
	a_chain: assert property (p_chain) else $error("sdo not driven in chain mode");
	property p_quiet; !busy && !$past(busy) && still_q > 4'h4 |-> $stable(sdoOut); endproperty
	a_quiet: assert property (p_quiet) else $error("sdo moved without an sck edge");
	property p_msb; $fell(busy) |=> $stable(sdoOut)[*3]; endproperty
	a_msb: assert property (p_msb) else $error("first bit not held after busy fell");
endmodule
`default_nettype wire

// ### sar_adc_convert_and_serial_readout_tb.sv
`default_nettype none
module sar_adc_convert_and_serial_readout_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic daisy = 1'b0;
	logic [RESULT_BITS-1:0] sample = 20'h00000;
	logic startReq = 1'b0;
	logic resultReady = 1'b0;
	logic ready, resultValid, poweredUp, acquiring;
	logic [RESULT_BITS-1:0] resultData;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
		$display("unexpected %s expected %h seen %h", nm, exp, got); end end
	adc_link_if link();
	adc_device #(.CONV_CYC(75), .ACQ_CYC(34)) adc_device_inst(.mclk(mclk), .rst_n(rst_n), .link(link.device),
		.daisyLinkSelect(daisy), .sampleValue(sample), .poweredUp(poweredUp), .acquiring(acquiring));
	adc_host #(.POR_CYC(20), .WORD_BITS(RESULT_BITS)) adc_host_inst(.mclk(mclk), .rst_n(rst_n), .link(link.host),
		.startReq(startReq), .ready(ready), .resultValid(resultValid), .resultReady(resultReady),
		.resultData(resultData));
	adc_link_checker #(.CONV_CYC(75)) adc_link_checker_inst(.mclk(mclk), .rst_n(rst_n), .daisyLinkSelect(daisy),
		.convertStart(link.convertStart), .busy(link.busy), .sck(link.sck), .selOrSerialIn(link.selOrSerialIn),
		.sdoOut(link.sdoOut), .sdoOen_n(link.sdoOen_n));
	// Clock and hang guard
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One conversion and readout of a known value
	task automatic convert(input logic [RESULT_BITS-1:0] v);
		int i;
		sample <= v;
		for (i = 0; i < 2000 && ready !== 1'b1; i++) @(posedge mclk);
		startReq <= 1'b1;
		@(posedge mclk) startReq <= 1'b0;
		for (i = 0; i < 20 && link.busy !== 1'b1; i++) @(posedge mclk);
		`CHK("awake", 1'b1, poweredUp)
		`CHK("acq hold", 1'b0, acquiring)
		repeat (ACQ_START_CYCLES - 1) @(posedge mclk);
		`CHK("acq late", 1'b0, acquiring)
		@(posedge mclk);
		`CHK("acq start", 1'b1, acquiring)
		for (i = 0; i < 200 && link.busy !== 1'b0; i++) @(posedge mclk);
		`CHK("asleep", 1'b0, poweredUp)
		for (i = 0; i < 2000 && resultValid !== 1'b1; i++) @(posedge mclk);
		`CHK("result", v, resultData)
		resultReady <= 1'b1;
		@(posedge mclk) resultReady <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// Reset in mid-run: outputs idle, host waits out the power-on time
	task automatic testReset();
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK("reset busy", 1'b0, link.busy)
		`CHK("reset release", 1'b1, link.sdoOen_n)
		`CHK("reset ready", 1'b0, ready)
		convert(20'h12345);
		$display("reset recovery done");
	endtask
	task automatic testNormal();
		convert(20'ha5c3e);
		convert(20'h5a3c1);
		`CHK("idle release", 1'b1, link.sdoOen_n)
		$display("normal readout done");
	endtask
	task automatic testEdges();
		convert(20'hfffff);
		convert(20'h80000);
		convert(20'h00001);
		$display("boundary words done");
	endtask
	task automatic testChain();
		daisy <= 1'b1;
		convert(20'h6b2d4);
		`CHK("chain drive", 1'b0, link.sdoOen_n)
		daisy <= 1'b0;
		$display("chain mode done");
	endtask
	// Fill the buffer with the reader stalled, then drain it
	task automatic testFifo();
		int i;
		int j;
		int n;
		n = 0;
		sample <= 20'h3c3c3;
		startReq <= 1'b1;
		repeat (3600) @(posedge mclk);
		`CHK("full refuses", 1'b0, ready)
		startReq <= 1'b0;
		for (i = 0; i < 40; i++) begin
			for (j = 0; j < 20 && resultValid !== 1'b1; j++) @(posedge mclk);
			if (resultValid === 1'b1) begin
				n++;
				`CHK("queued", 20'h3c3c3, resultData)
				resultReady <= 1'b1;
				@(posedge mclk) resultReady <= 1'b0;
				repeat (2) @(posedge mclk);
			end
		end
		`CHK("drained", FIFO_DEPTH + 1, n)
		$display("buffer fill and drain done");
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		testNormal();
		testEdges();
		testChain();
		testReset();
		testFifo();
		conclude();
	end
endmodule
`default_nettype wire
